// ==== shared/acsh_defines.svh ====
// Functional notes
// - busy rises on start, falls after all converted
// - first-result flag high while pointer at register one
// - start edge holds all four channels together
// - channel selection captured on start edge
// - read and write strobes ignored while chip select high
// - data driven only while read and select low
// - write rising edge stores data_line_zero..three
// - hardware include pin one includes channel
// - sequence source pin picks register or pins
// - external clock: sixteen cycles per channel
`ifndef ACSH_DEFINES_SVH
`define ACSH_DEFINES_SVH
`define ACSH_NCH 4
`define ACSH_DW 14
`define ACSH_EXT_CYCLES 5'h10
`define ACSH_INT_CYCLES 5'h10
`define ACSH_SEL_RST 4'hF
`define ACSH_CNT_ONE 5'h01
`define ACSH_ZERO5 5'h00
`endif

// ==== shared/acsh_pkg.sv ====
package acsh_pkg;
	typedef logic [3:0] acsh_mask_t; // one bit per channel
	typedef logic [13:0] acsh_word_t; // one conversion result
	typedef enum logic [1:0] {ACSH_IDLE, ACSH_CONV, ACSH_NEXT} acsh_state_t;
endpackage : acsh_pkg

// ==== shared/acsh_res_if.sv ====
`timescale 1ns/1ns
// result hand-off between converter core and host port
interface acsh_res_if;
	logic wr; // one-cycle result write
	logic [1:0] ch; // channel of result
	logic [13:0] data; // result word
	logic start; // new sequence began
	modport core (output wr, output ch, output data, output start);
	modport port (input wr, input ch, input data, input start);
endinterface : acsh_res_if

// ==== logic/acsh_result_regs.sv ====
`timescale 1ns/1ns
`include "acsh_defines.svh"
// result registers and read pointer
module acsh_result_regs (
	input wire logic i_core_clk, // core clock
	input wire logic i_arst_n, // async reset
	acsh_res_if.port res, // results from core
	input wire acsh_pkg::acsh_mask_t i_seq, // latched sequence
	input wire logic i_rd_done, // read finished pulse
	output logic [13:0] o_word, // word at pointer
	output logic o_first // pointer at register one
);
	import acsh_pkg::*;
	acsh_word_t mem_ff [`ACSH_NCH]; // result registers
	logic [1:0] ptr_ff; // output pointer
	logic [1:0] first_ch; // lowest selected channel
	logic [1:0] nxt_ptr; // next selected channel
	// storage of results
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (int i = 0; i < `ACSH_NCH; i++) mem_ff[i] <= '0;
		end else if (res.wr) begin
			mem_ff[res.ch] <= res.data;
		end
	end
	// lowest and next selected channels
	always_comb begin
		first_ch = 2'h0;
		nxt_ptr = ptr_ff;
		for (int i = `ACSH_NCH - 1; i >= 0; i--) begin
			if (i_seq[i]) first_ch = 2'(i);
		end
		for (int i = `ACSH_NCH - 1; i >= 0; i--) begin
			if (i_seq[i] && 2'(i) > ptr_ff) nxt_ptr = 2'(i);
		end
		if (nxt_ptr == ptr_ff) nxt_ptr = first_ch;
	end
	// pointer walk
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ptr_ff <= 2'h0;
		end else if (res.start) begin
			ptr_ff <= first_ch;
		end else if (i_rd_done) begin
			ptr_ff <= nxt_ptr;
		end
	end
	assign o_word = mem_ff[ptr_ff];
	assign o_first = (ptr_ff == first_ch);
	a_ptr_restart: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		res.start |=> ptr_ff == $past(first_ch)) else $error("pointer not reset");
endmodule : acsh_result_regs

// ==== logic/acsh_top.sv ====
`timescale 1ns/1ns
`include "acsh_defines.svh"
// conversion control and parallel host port
module acsh_top (
	input wire logic i_core_clk, // core clock
	input wire logic i_arst_n, // async reset
	input wire logic i_conversion_start_n, // start strobe, rising edge
	input wire logic i_cs_n, // chip select
	input wire logic i_rd_n, // read strobe
	input wire logic i_wr_n, // write strobe
	input wire logic i_sw_seq_sel, // high: register sequence
	input wire logic i_ext_clk_sel, // high: external clock, register sequence mode only
	input wire logic i_ext_conv_clk, // external conversion clock, sampled
	input wire logic i_hw_include_ch1, // channel 1 include
	input wire logic i_hw_include_ch2, // channel 2 include
	input wire logic i_hw_include_ch3, // channel 3 include
	input wire logic i_hw_include_ch4, // channel 4 include
	input wire logic [13:0] i_db, // data bus in
	input wire logic [55:0] i_sample, // analog samples, 4x14
	output logic [13:0] o_db, // data bus out
	output logic o_db_oe_n, // bus enable, low drives
	output logic o_busy, // sequence running
	output logic o_first_result_flag, // pointer at register one
	output logic o_hold, // track/holds in hold
	output logic o_eoc_n // end of each conversion
);
	import acsh_pkg::*;
	acsh_res_if res (); // results to register file
	logic cst_ff, wr_ff, rd_ff; // strobe delays
	logic eclk_ff; // external clock delay
	acsh_mask_t sel_ff; // software channel select
	acsh_mask_t seq_ff; // latched sequence
	acsh_mask_t left_ff; // channels still to convert
	acsh_state_t st_ff; // sequencer state
	logic [4:0] cnt_ff; // cycles in conversion
	logic [1:0] ch_ff; // channel converting
	logic [55:0] held_ff; // held samples
	logic busy_ff, eoc_ff, oe_ff; // outputs
	logic [13:0] db_ff; // bus data
	logic start, wr_rise, rd_end, tick; // events
	acsh_mask_t seq_src; // chosen sequence
	logic [1:0] low_ch; // lowest remaining channel
	logic [13:0] word; // word at pointer
	logic rd_act; // read enabled
	logic start_d_ff; // start seen last cycle, seq_ff now valid
	assign start = i_conversion_start_n && !cst_ff && st_ff == ACSH_IDLE;
	assign rd_act = !i_cs_n && !i_rd_n;
	assign wr_rise = i_wr_n && !wr_ff && !i_cs_n && i_rd_n;
	assign rd_end = i_rd_n && !rd_ff && !i_cs_n;
	// conversion clock: external edges only in software mode
	assign tick = (i_sw_seq_sel && i_ext_clk_sel) ? (i_ext_conv_clk && !eclk_ff) : 1'b1;
	// sequence source select
	assign seq_src = i_sw_seq_sel ? sel_ff :
		{i_hw_include_ch4, i_hw_include_ch3, i_hw_include_ch2, i_hw_include_ch1};
	// lowest remaining channel
	always_comb begin
		low_ch = 2'h0;
		for (int i = `ACSH_NCH - 1; i >= 0; i--) begin
			if (left_ff[i]) low_ch = 2'(i);
		end
	end
	// strobe edge history
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cst_ff <= 1'b1;
			wr_ff <= 1'b1;
			rd_ff <= 1'b1;
			eclk_ff <= 1'b0;
		end else begin
			cst_ff <= i_conversion_start_n;
			wr_ff <= i_wr_n;
			rd_ff <= i_rd_n;
			eclk_ff <= i_ext_conv_clk;
		end
	end
	// start delayed one cycle so the pointer restarts on the new sequence
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			start_d_ff <= 1'b0;
		end else begin
			start_d_ff <= start;
		end
	end
	// software channel select register
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sel_ff <= `ACSH_SEL_RST;
		end else if (wr_rise) begin
			sel_ff <= i_db[3:0];
		end
	end
	// sequencer
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_ff <= ACSH_IDLE;
			seq_ff <= '0;
			left_ff <= '0;
			cnt_ff <= `ACSH_ZERO5;
			ch_ff <= 2'h0;
			held_ff <= '0;
			busy_ff <= 1'b0;
			eoc_ff <= 1'b1;
		end else begin
			eoc_ff <= 1'b1;
			case (st_ff)
				// waiting for an accepted start edge
				ACSH_IDLE: begin
					if (start) begin
						seq_ff <= seq_src;
						left_ff <= seq_src;
						held_ff <= i_sample;
						busy_ff <= 1'b1;
						st_ff <= ACSH_NEXT;
					end
				end
				// pick the lowest remaining channel or finish
				ACSH_NEXT: begin
					if (left_ff == '0) begin
						busy_ff <= 1'b0;
						st_ff <= ACSH_IDLE;
					end else begin
						ch_ff <= low_ch;
						left_ff[low_ch] <= 1'b0;
						cnt_ff <= `ACSH_ZERO5;
						st_ff <= ACSH_CONV;
					end
				end
				// count conversion ticks for the current channel
				ACSH_CONV: begin
					if (tick) begin
						cnt_ff <= cnt_ff + `ACSH_CNT_ONE;
						if (cnt_ff == ((i_sw_seq_sel && i_ext_clk_sel) ? `ACSH_EXT_CYCLES : `ACSH_INT_CYCLES)
							- `ACSH_CNT_ONE) begin
							eoc_ff <= 1'b0;
							st_ff <= ACSH_NEXT;
						end
					end
				end
				// stray code falls back to idle
				default: st_ff <= ACSH_IDLE;
			endcase
		end
	end
	// result hand-off, restart one cycle after the start edge
	assign res.start = start_d_ff;
	assign res.wr = st_ff == ACSH_CONV && !eoc_ff == 1'b0 && tick &&
		cnt_ff == ((i_sw_seq_sel && i_ext_clk_sel) ? `ACSH_EXT_CYCLES : `ACSH_INT_CYCLES) - `ACSH_CNT_ONE;
	assign res.ch = ch_ff;
	assign res.data = held_ff[ch_ff * `ACSH_DW +: `ACSH_DW];
	acsh_result_regs u_regs (
		.i_core_clk(i_core_clk),
		.i_arst_n(i_arst_n),
		.res(res),
		.i_seq(seq_ff),
		.i_rd_done(rd_end),
		.o_word(word),
		.o_first(o_first_result_flag)
	);
	// read bus drive
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			oe_ff <= 1'b0;
			db_ff <= '0;
		end else begin
			oe_ff <= rd_act;
			db_ff <= rd_act ? word : db_ff;
		end
	end
	// outputs from their registers, bus enable also gated by the live read
	assign o_db = db_ff;
	assign o_db_oe_n = !(oe_ff && rd_act);
	assign o_busy = busy_ff;
	assign o_hold = busy_ff;
	assign o_eoc_n = eoc_ff;
	// busy follows an accepted start by one cycle
	a_busy_rise: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		start |=> o_busy) else $error("busy not raised");
	// busy only drops with nothing left to convert
	a_busy_end: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		$fell(o_busy) |-> left_ff == '0) else $error("busy fell early");
	// selection captured from its source at the start edge
	a_seq_latch: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		start |=> seq_ff == $past(seq_src)) else $error("sequence not latched");
	// latched selection frozen while the sequence runs
	a_seq_stable: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		o_busy && $past(o_busy) |-> $stable(seq_ff)) else $error("sequence changed");
	// bus enable only inside a selected read
	a_bus_drive: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		!o_db_oe_n |-> !i_cs_n && !i_rd_n) else $error("bus driven outside read");
	// write edge stores the low data lines
	a_wr_store: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		wr_rise |=> sel_ff == $past(i_db[3:0])) else $error("select not stored");
	// deselected strobes leave the select register alone
	a_cs_ignore: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		i_cs_n |=> $stable(sel_ff)) else $error("write while deselected");
	// all four samples held together at the start edge
	a_hold_start: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		start |=> held_ff == $past(i_sample) && o_hold) else $error("samples not held");
	// pin mode takes include pin one for channel one
	a_hw_src: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		start && !i_sw_seq_sel |=> seq_ff[0] == $past(i_hw_include_ch1)) else $error("pin select lost");
	// bus carries the word addressed one cycle earlier
	a_bus_data: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		!o_db_oe_n |-> o_db == $past(word)) else $error("bus data wrong");
	// empty remainder ends the sequence
	a_seq_done: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		st_ff == ACSH_NEXT && left_ff == '0 |=> !o_busy) else $error("busy held after last channel");
	// one finished channel: a single low cycle
	sequence s_eoc_pulse;
		!o_eoc_n ##1 o_eoc_n;
	endsequence
	// channel picked while running from the internal clock
	sequence s_pick_int;
		st_ff == ACSH_NEXT && left_ff != '0 && !(i_sw_seq_sel && i_ext_clk_sel);
	endsequence
	// sixteen ticks with end of conversion high, then its low pulse
	sequence s_conv_int;
		##1 o_eoc_n [*8] ##1 o_eoc_n [*8] ##1 !o_eoc_n;
	endsequence
	a_eoc_single: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		$fell(o_eoc_n) |-> s_eoc_pulse) else $error("end of conversion pulse too long");
	a_conv_length: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		s_pick_int |-> s_conv_int) else $error("conversion length wrong");
endmodule : acsh_top

// ==== testbench/acsh_host_model.sv ====
`timescale 1ns/1ns
// host bus model, strobes move on the falling edge
module acsh_host_model (
	input wire logic i_core_clk, // core clock
	input wire logic i_oe_n, // device bus enable
	output logic o_cs_n, // chip select
	output logic o_rd_n, // read strobe
	output logic o_wr_n, // write strobe
	output logic o_start_n, // conversion start
	output logic [13:0] o_db // bus toward device
);
	// idle bus, lines inverted once released
	initial begin
		{o_cs_n, o_rd_n, o_wr_n, o_start_n, o_db} = {4'hF, 14'h0000};
	end
	// low pulse, rising edge starts
	task automatic pulse_start();
		@(negedge i_core_clk) o_start_n = 1'b0;
		@(negedge i_core_clk) o_start_n = 1'b1;
	endtask : pulse_start
	// select write, bus driven across the rising write edge
	task automatic write_sel(input logic [3:0] m, input logic cs);
		@(negedge i_core_clk) {o_cs_n, o_wr_n, o_db} = {cs, 1'b0, 10'h000, m};
		@(negedge i_core_clk) o_wr_n = 1'b1;
		@(negedge i_core_clk) {o_cs_n, o_db} = {1'b1, 10'h3FF, ~m};
	endtask : write_sel
	// read: hold until enable seen at an edge; write stays high
	task automatic read_word(output bit ok);
		ok = 0;
		@(negedge i_core_clk) {o_cs_n, o_rd_n} = 2'h0;
		for (int i = 0; i < 8 && !ok; i++) begin
			@(posedge i_core_clk) ok = (i_oe_n === 1'b0);
		end
		// read strobe rises while still selected, so the pointer steps
		@(negedge i_core_clk) o_rd_n = 1'b1;
		@(negedge i_core_clk) o_cs_n = 1'b1;
	endtask : read_word
endmodule : acsh_host_model

// ==== testbench/tb.sv ====
`timescale 1ns/1ns
module tb;
	import acsh_pkg::*;
	logic clk, rst_n, cs_n, rd_n, wr_n, st_n, sw, ext, eclk, oe_n, busy, first, hold, eoc_n;
	logic [3:0] hw; // include pins
	logic [13:0] db, q_db; // bus both ways
	logic [55:0] smp; // samples
	acsh_word_t exp_q[$]; // expected read words
	int n_mismatch, tests_run, erise, n_eoc;
	// core clock
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	// external conversion clock, half core rate
	always @(negedge clk) eclk <= (eclk !== 1'b1);
	always @(posedge eclk) erise <= erise + busy;
	acsh_host_model host (.i_core_clk(clk), .i_oe_n(oe_n), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n),
		.o_start_n(st_n), .o_db(db));
	acsh_top dut (.i_core_clk(clk), .i_arst_n(rst_n), .i_conversion_start_n(st_n), .i_cs_n(cs_n),
		.i_rd_n(rd_n), .i_wr_n(wr_n), .i_sw_seq_sel(sw), .i_ext_clk_sel(ext), .i_ext_conv_clk(eclk),
		.i_hw_include_ch1(hw[0]), .i_hw_include_ch2(hw[1]), .i_hw_include_ch3(hw[2]),
		.i_hw_include_ch4(hw[3]), .i_db(db), .i_sample(smp), .o_db(q_db), .o_db_oe_n(oe_n),
		.o_busy(busy), .o_first_result_flag(first), .o_hold(hold), .o_eoc_n(eoc_n));
	task automatic check(input string nm, input logic [13:0] e, input logic [13:0] s);
		tests_run++;
		if (e !== s) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : check
	task automatic stop_test();
		$display("mismatches %0d of %0d checks", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : stop_test
	// watcher: each enabled edge takes the oldest note
	always @(posedge clk) begin
		if (oe_n === 1'b0) begin
			if (exp_q.size() == 0) check("read note", 1'b1, 1'b0);
			else check("o_db", exp_q.pop_front(), q_db);
			check("bus enable", 1'b0, cs_n | rd_n);
		end
		if (rst_n) check("hold", busy, hold);
		if (eoc_n === 1'b0) n_eoc++;
	end
	// one sequence: select, start, disturb selection, drain results
	task automatic run_seq(input logic [3:0] m, input logic s, input logic x);
		bit ok;
		int n;
		logic [55:0] held; // samples at the start edge
		{sw, ext} = {s, x};
		n_eoc = 0;
		if (s) host.write_sel(m, 1'b0);
		else hw = m;
		host.write_sel(~m, 1'b1);
		host.pulse_start();
		@(negedge clk);
		hw = ~m;
		held = smp;
		smp = 56'({$urandom, $urandom});
		check("busy rise", 1'b1, busy);
		if (s) host.write_sel(~m, 1'b0);
		else host.pulse_start();
		for (n = 0; n < 3000 && busy !== 1'b0; n++) @(negedge clk);
		check("busy fall", 1'b0, busy);
		if (busy !== 1'b0) stop_test();
		if (!x) check("busy cycles", 14'(17 * $countones(m) + 1), 14'(n + (s ? 3 : 2)));
		if (x) check("ext ticks", 1'b1, erise >= 16 * $countones(m) && erise <= 17 * $countones(m) + 1);
		check("eoc count", 14'($countones(m)), 14'(n_eoc));
		n = 0;
		for (int c = 0; c < 4; c++) if (m[c]) begin
			@(negedge clk);
			check("first flag", n == 0, first);
			exp_q.push_back(held[c*14 +: 14]);
			host.read_word(ok);
			check("read taken", 1'b1, ok);
			if (!ok) stop_test();
			n++;
		end
		@(negedge clk);
		check("first wrap", 1'b1, first);
		check("notes left", 14'h0000, 14'(exp_q.size()));
		erise = 0;
	endtask : run_seq
	initial begin
		{rst_n, sw, ext, eclk, hw, smp, n_mismatch, tests_run, erise} = '0;
		void'($urandom(32'h66d4));
		repeat (10) @(negedge clk);
		rst_n = 1;
		check("busy reset", 1'b0, busy);
		check("oe reset", 1'b1, oe_n);
		for (int t = 0; t < 12; t++) begin
			smp = 56'({$urandom, $urandom});
			run_seq(t < 3 ? 4'hF : 4'($urandom_range(1, 15)), t % 3 != 0, t % 3 == 2);
		end
		stop_test();
	end
endmodule : tb
